/* File: logic/cdma_defines.svh */
// Purpose: Constants of the chaining DMA control map
// Assumes: Byte addresses as seen behind the BAR match
// Notes:   Definitions only
`ifndef CDMA_DEFINES_SVH
`define CDMA_DEFINES_SVH
// Target memory: 32 KByte, one dword per word
`define CDMA_MEM_WORDS    8192
`define CDMA_MEM_AW       13
// Control and status offsets, bytes from the CSR BAR
`define CDMA_WR_CTRL0     8'h00
`define CDMA_WR_BASE_HI   8'h04
`define CDMA_WR_BASE_LO   8'h08
`define CDMA_WR_LAST      8'h0C
`define CDMA_RD_CTRL0     8'h10
`define CDMA_RD_BASE_HI   8'h14
`define CDMA_RD_BASE_LO   8'h18
`define CDMA_RD_LAST      8'h1C
`define CDMA_WR_STAT_HI   8'h20
`define CDMA_WR_STAT_LO   8'h24
`define CDMA_RD_STAT_HI   8'h28
`define CDMA_RD_STAT_LO   8'h2C
`define CDMA_ERR_STAT     8'h30
// Control field bit positions
`define CDMA_CIE_BIT      17
`define CDMA_DWE_BIT      18
`define CDMA_VEC_LSB      20
`define CDMA_CLS_LSB      28
`define CDMA_LOOP_BIT     31
// Writable bits; reserved bits stay zero
`define CDMA_CTRL0_MASK   32'hF1F6FFFF
`define CDMA_LAST_MASK    32'h0000FFFF
// Reset values: write engine on vector 1, read on 0
`define CDMA_WR_CTRL0_RST 32'h00100000
`define CDMA_RD_CTRL0_RST 32'h00000000
// One descriptor is four dwords
`define CDMA_DESC_BYTES   64'h0000000000000010
// Version field of the write status, value arbitrary
`define CDMA_VERSION      4'h1
`endif

/* File: logic/cdma_pkg.sv */
// Purpose: Types of the chaining DMA control map
// Assumes: Used with cdma_defines.svh
// Notes:   Structs carry grouped signals
package cdma_pkg;
  // Received memory request, one per cycle at most
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [5:0]  barHit;
    logic [14:0] addr;
    logic [3:0]  be;
    logic [31:0] data;
  } cdma_req_t;
  // Read completion
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } cdma_rsp_t;
  // Per engine status from the requester side
  typedef struct packed {
    logic        descDone;
    logic        fifoEmpty;
    logic [31:0] perfCount;
  } cdma_stat_t;
  // Link wide configuration shown in status
  typedef struct packed {
    logic [2:0]  maxPayload;
    logic [2:0]  maxReadReq;
    logic [3:0]  linkWidth;
    logic [15:0] ecrcErrors;
  } cdma_cfg_t;
  // Per engine commands toward fetch, MSI and write-back
  typedef struct packed {
    logic        running;
    logic        fetchValid;
    logic [63:0] fetchAddr;
    logic        msiValid;
    logic [4:0]  msiVector;
    logic [2:0]  msiClass;
    logic        wbValid;
    logic [15:0] wbIndex;
  } cdma_eng_t;
  typedef enum logic {CDMA_IDLE, CDMA_RUN} cdma_state_t;
endpackage

/* File: logic/cdma_control_map.sv */
// Purpose: BAR steering, target memory and DMA control
// Assumes: Requests and status synchronous to clk
// Notes:   Engine index 0 is write DMA, 1 is read DMA
// Notes:   Target memory holds no reset value
// Notes on behaviour
// - Memory BARs reach 32 KByte target memory
// - BAR2/3 reach DMA control, 256 bytes
// - Target accesses bypass the DMA engines
// - Dword 0: count low, control high
// - Dwords 4, 8: write table base
// - Dword C low 16: write last index
// - Read dwords 10-18 mirror write layout
// - Dword 1C low 16: read last index
// - All eight control dwords read/write
// - Bit 17 sends MSI per descriptor
// - Bit 18 writes back completed index
// - Bits 24:20 drive MSI vector
// - Default vectors: read 0, write 1
// - Bits 30:28 drive MSI class, default 0
// - Bit 31 loops; clear stops at last
// - Status registers are read only
// - Engines fetch four-dword descriptors
// - Every register is 32 bits
`include "cdma_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module cdma_control_map
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire cdma_pkg::cdma_req_t    req,
  output var  cdma_pkg::cdma_rsp_t    rsp,
  input  wire cdma_pkg::cdma_stat_t   engStat [2],
  input  wire cdma_pkg::cdma_cfg_t    cfg,
  output var  cdma_pkg::cdma_eng_t    engOut  [2]
);
  import cdma_pkg::*;

  // ----------------------------------------------
  // Request decode
  // ----------------------------------------------
  // Memory BARs and their 64-bit pairs
  wire logic        memBar;
  // Control and status BARs
  wire logic        csrBar;
  // Dword index into the target memory
  wire logic [`CDMA_MEM_AW-1:0] memIdx;
  // Byte offset of a CSR, dword aligned
  wire logic [7:0]  csrOff;
  // Request lands in the eight control dwords
  wire logic        ctrlHit;
  // Control dword number 0..7
  wire logic [2:0]  ctrlIdx;
  // Write strobe of the target memory
  wire logic        memWr;
  // Write strobe of the control dwords
  wire logic        ctrlWr;

  assign memBar  = req.barHit[0] | req.barHit[1]
                 | req.barHit[4] | req.barHit[5];
  assign csrBar  = req.barHit[2] | req.barHit[3];
  assign memIdx  = req.addr[14:2];
  // 256 byte window
  // Only the low byte is decoded, so the 256 byte map
  // repeats across a larger BAR; cheaper than a full
  // compare and harmless, as software uses the base copy
  assign csrOff  = {req.addr[7:2], 2'b00};
  // Offsets 0x00 to 0x1C hold the control dwords
  assign ctrlHit = csrBar & (csrOff[7:5] == 3'h0);
  assign ctrlIdx = csrOff[4:2];
  assign memWr   = req.valid & req.write & memBar;
  assign ctrlWr  = req.valid & req.write & ctrlHit;

  // ----------------------------------------------
  // Target memory
  // ----------------------------------------------
  // 32 KByte of target storage
  // Not reset: contents are only defined once written,
  // which keeps the array free to map onto block RAM
  logic [31:0] mem [`CDMA_MEM_WORDS];
  // Asynchronous read, registered in the completion
  wire logic [31:0] memRdData;
  assign memRdData = mem[memIdx];

  // Byte lanes follow the request enables
  // Each lane is its own slice, so no read-modify-write
  always_ff @(posedge clk)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (memWr && req.be[b])
      begin
        mem[memIdx][b*8 +: 8] <= req.data[b*8 +: 8];
      end
    end
  end

  // ----------------------------------------------
  // Control dwords
  // ----------------------------------------------
  // Four dwords per engine, write engine first
  logic [31:0] ctrl_reg [8];
  // Writable bit mask per dword
  wire logic [31:0] ctrlMask;
  // Masked write data with byte enables applied
  wire logic [31:0] ctrl_next;
  // Byte enables widened to one bit per data bit
  wire logic [31:0] beMask;

  assign ctrlMask = (ctrlIdx[1:0] == 2'h0) ? `CDMA_CTRL0_MASK
                  : (ctrlIdx[1:0] == 2'h3) ? `CDMA_LAST_MASK
                  : 32'hFFFFFFFF;
  assign beMask   = {{8{req.be[3]}}, {8{req.be[2]}},
                     {8{req.be[1]}}, {8{req.be[0]}}};
  // Lanes not enabled keep their stored value
  assign ctrl_next = ((req.data & beMask)
                   | (ctrl_reg[ctrlIdx] & ~beMask)) & ctrlMask;

  // Resets give vector 1 to write, vector 0 to read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int r = 0; r < 8; r++)
      begin
        ctrl_reg[r] <= 32'h00000000;
      end
      ctrl_reg[0] <= `CDMA_WR_CTRL0_RST;
      ctrl_reg[4] <= `CDMA_RD_CTRL0_RST;
    end
    else if (ctrlWr)
    begin
      ctrl_reg[ctrlIdx] <= ctrl_next;
    end
  end

  // ----------------------------------------------
  // Status words, read only
  // ----------------------------------------------
  // High status dword of the write engine
  wire logic [31:0] wrStatHi;
  // High status dword of the read engine
  wire logic [31:0] rdStatHi;
  // Last completed index per engine
  logic [15:0] doneIdx_reg [2];

  // status built from state
  // No register stands behind these words, so a host
  // write to them has nothing to change
  assign wrStatHi = {`CDMA_VERSION, 4'h0, cfg.maxPayload,
                     4'h0, engStat[0].fifoEmpty, doneIdx_reg[0]};
  assign rdStatHi = {8'h00, cfg.maxReadReq, cfg.linkWidth,
                     engStat[1].fifoEmpty, doneIdx_reg[1]};

  // ----------------------------------------------
  // Read completion
  // ----------------------------------------------
  // CSR read data; unmapped offsets read zero
  logic [31:0] csrRdData;
  // Read request taken this cycle
  wire logic        rdReq;
  // Read data chosen by BAR group
  wire logic [31:0] rdData;

  always_comb
  begin
    csrRdData = 32'h00000000;
    // Status words first; the low offsets go to control
    case (csrOff)
      `CDMA_WR_STAT_HI: csrRdData = wrStatHi;
      `CDMA_WR_STAT_LO: csrRdData = engStat[0].perfCount;
      `CDMA_RD_STAT_HI: csrRdData = rdStatHi;
      `CDMA_RD_STAT_LO: csrRdData = engStat[1].perfCount;
      `CDMA_ERR_STAT:   csrRdData = {16'h0000, cfg.ecrcErrors};
      default:
      begin
        if (ctrlHit)
        begin
          csrRdData = ctrl_reg[ctrlIdx];
        end
      end
    endcase
  end

  // Every read is answered; no BAR hit answers zero
  assign rdReq  = req.valid & ~req.write;
  // Memory wins when both BAR groups claim a request
  assign rdData = memBar ? memRdData
                : csrBar ? csrRdData
                : 32'h00000000;

  // Completion one cycle after the request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp <= '0;
    end
    else
    begin
      rsp.valid <= rdReq;
      // Zero between completions, so no stale word lingers
      rsp.data  <= rdReq ? rdData : 32'h00000000;
    end
  end

  // ----------------------------------------------
  // Engine sequencing, one copy per direction
  // ----------------------------------------------
  for (genvar e = 0; e < 2; e++)
  begin : g_eng
    // Field views of this engine's control dwords
    wire logic [31:0] ctl0;
    wire logic [63:0] tableBase;
    wire logic [15:0] lastIdx;
    // Writing the last-index dword launches
    wire logic        start;
    // Descriptor in work is the last one to process
    wire logic        atLast;
    // Idle or running
    cdma_state_t      state_reg;
    // Index of the descriptor in work
    logic [15:0]      curIdx_reg;

    // --------------------------------------------
    // Field views
    // --------------------------------------------
    // read copy mirrors write
    // Engine e owns dwords 4e to 4e+3
    assign ctl0      = ctrl_reg[e*4];
    // table base halves
    // Upper dword first, lower dword in bits 31:0
    assign tableBase = {ctrl_reg[e*4+1], ctrl_reg[e*4+2]};
    assign lastIdx   = ctrl_reg[e*4+3][15:0];
    // launch on dword 3
    // The count in dword 0 is not used here: the last
    // index alone bounds the walk through the table
    assign start     = ctrlWr && (ctrlIdx == 3'(e*4+3));
    assign atLast    = (curIdx_reg == lastIdx);

    // --------------------------------------------
    // Descriptor sequencing
    // --------------------------------------------
    // Descriptor progress; a relaunch restarts at 0
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        state_reg  <= CDMA_IDLE;
        curIdx_reg <= 16'h0000;
        engOut[e]  <= '0;
        doneIdx_reg[e] <= 16'h0000;
      end
      else
      begin
        // Pulses last one cycle
        // Cleared every edge and set below where due
        engOut[e].fetchValid <= 1'b0;
        engOut[e].msiValid   <= 1'b0;
        engOut[e].wbValid    <= 1'b0;
        // Copied every edge, so a new field shows a cycle late
        // vector follows field
        engOut[e].msiVector  <= ctl0[`CDMA_VEC_LSB +: 5];
        engOut[e].msiClass   <= ctl0[`CDMA_CLS_LSB +: 3];
        case (state_reg)
          CDMA_IDLE:
          begin
            // Completions while idle are ignored
            if (start)
            begin
              state_reg  <= CDMA_RUN;
              curIdx_reg <= 16'h0000;
              engOut[e].running    <= 1'b1;
              engOut[e].fetchValid <= 1'b1;
              engOut[e].fetchAddr  <= tableBase;
            end
          end
          CDMA_RUN:
          begin
            if (start)
            begin
              // Relaunch while running restarts the table
              curIdx_reg <= 16'h0000;
              engOut[e].fetchValid <= 1'b1;
              engOut[e].fetchAddr  <= tableBase;
            end
            // A completion that meets a relaunch is dropped,
            // as it belongs to the table just abandoned
            else if (engStat[e].descDone)
            begin
              // Shown in the status word as the last done
              doneIdx_reg[e] <= curIdx_reg;
              engOut[e].msiValid <= ctl0[`CDMA_CIE_BIT];
              engOut[e].wbValid  <= ctl0[`CDMA_DWE_BIT];
              engOut[e].wbIndex  <= curIdx_reg;
              if (atLast && !ctl0[`CDMA_LOOP_BIT])
              begin
                state_reg <= CDMA_IDLE;
                engOut[e].running <= 1'b0;
              end
              // Loop bit set: back to descriptor 0
              else if (atLast)
              begin
                curIdx_reg <= 16'h0000;
                engOut[e].fetchValid <= 1'b1;
                engOut[e].fetchAddr  <= tableBase;
              end
              else
              begin
                // Each descriptor spans 16 bytes of the table
                // next four dwords
                curIdx_reg <= curIdx_reg + 16'h0001;
                engOut[e].fetchValid <= 1'b1;
                engOut[e].fetchAddr  <= tableBase
                  + ({48'h0, curIdx_reg + 16'h0001} << 4);
              end
            end
          end
          default:
          begin
            // Unreachable; recovers from a corrupted state
            state_reg <= CDMA_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: verif/cdma_checker_assertions.sv */
// Purpose: Port checks of cdma_control_map
// Assumes: One clock, reset async active low
// Notes:   Bound to every instance below
`timescale 1ns/100ps
`default_nettype none
module cdma_checker
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire cdma_pkg::cdma_req_t  req,
  input wire cdma_pkg::cdma_rsp_t  rsp,
  input wire cdma_pkg::cdma_stat_t engStat [2],
  input wire cdma_pkg::cdma_eng_t  engOut  [2]
);
  import cdma_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Write into the control space
  wire logic csrWr = req.valid & req.write & (req.barHit[2] | req.barHit[3]);
  // Last-index writes launch the engines
  wire logic wrStart = csrWr & (req.addr[14:2] == 13'h0003);
  wire logic rdStart = csrWr & (req.addr[14:2] == 13'h0007);
  wire logic rdReq   = req.valid & ~req.write;
  rd_answer_a: assert property (rdReq |=> rsp.valid)
    else $error("read got no completion");
  no_extra_a: assert property (!rdReq |=> !rsp.valid)
    else $error("completion without a read");
  wr_start_a: assert property (
    wrStart |=> engOut[0].fetchValid && engOut[0].running)
    else $error("write engine did not start");
  rd_start_a: assert property (
    rdStart |=> engOut[1].fetchValid && engOut[1].running)
    else $error("read engine did not start");
  msi_cause_a: assert property (
    engOut[1].msiValid
    |-> $past(engStat[1].descDone && engOut[1].running))
    else $error("interrupt without completion");
  wb_cause_a: assert property (
    engOut[0].wbValid
    |-> $past(engStat[0].descDone && engOut[0].running))
    else $error("write-back without completion");
  stop_cause_a: assert property (
    $fell(engOut[1].running) |-> $past(engStat[1].descDone))
    else $error("engine stopped without completion");
  fetch_cause_a: assert property (
    engOut[1].fetchValid
    |-> $past(engStat[1].descDone && engOut[1].running)
        || $past(rdStart))
    else $error("fetch without cause");
  cover property (rsp.valid);
  cover property (engOut[0].wbValid);
  cover property ($fell(engOut[1].running));
endmodule
bind cdma_control_map cdma_checker chk (.clk(clk), .rst_n(rst_n),
  .req(req), .rsp(rsp), .engStat(engStat), .engOut(engOut));
`default_nettype wire

/* File: verif/cdma_engine_model.sv */
// Purpose: Requester side answering descriptor fetches
// Assumes: One fetch in flight per engine
// Notes:   DLY sets how slowly a descriptor completes
`timescale 1ns/100ps
`default_nettype none
module cdma_engine_model #(parameter int DLY = 1)
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire cdma_pkg::cdma_eng_t  eng,
  output var  cdma_pkg::cdma_stat_t stat
);
  import cdma_pkg::*;
  logic [7:0] waitReg; // Cycles left on the descriptor
  logic       busyReg; // Descriptor in flight
  wire  logic doneNow = busyReg & (waitReg == 8'h00);
  // four-dword fetch and transfer as one delay
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busyReg <= 1'b0;
      waitReg <= 8'h00;
      stat    <= '0;
    end
    else
    begin
      stat.descDone  <= doneNow;
      stat.fifoEmpty <= ~busyReg;
      stat.perfCount <= stat.perfCount + {31'h0, eng.running};
      // A new fetch restarts the count, so a restart is obeyed
      if (eng.fetchValid)
      begin
        busyReg <= 1'b1;
        waitReg <= 8'(DLY);
      end
      else if (doneNow)
        busyReg <= 1'b0;
      else if (busyReg)
        waitReg <= waitReg - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: verif/chaining_dma_control_map_bench.sv */
// Purpose: Self-checking bench of cdma_control_map
// Assumes: Answer visible just after the taking edge
// Notes:   Engine 0 answered promptly, engine 1 slowly
`timescale 1ns/100ps
`default_nettype none
module chaining_dma_control_map_bench;
  import cdma_pkg::*;
  logic        clk;
  logic        rst_n;
  cdma_req_t   req;
  cdma_rsp_t   rsp;
  cdma_rsp_t   seen;
  wire cdma_stat_t engStat [2];
  cdma_cfg_t   cfg;
  cdma_eng_t   engOut [2];
  int          error_cnt = 0;
  int          checked = 0;
  int          nF [2] = '{0, 0};
  int          nM [2] = '{0, 0};
  int          nW = 0;
  logic [31:0] lastAddr [2];
  logic [7:0]  msiTag [2];
  logic [15:0] lastIdx;
  // only implemented memory BARs are used
  logic [5:0]  mb [4] = '{6'h01, 6'h02, 6'h10, 6'h20};
  cdma_control_map uut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
    .engStat(engStat), .cfg(cfg), .engOut(engOut));
  cdma_engine_model #(.DLY(1)) wrSide (.clk(clk), .rst_n(rst_n),
    .eng(engOut[0]), .stat(engStat[0]));
  cdma_engine_model #(.DLY(7)) rdSide (.clk(clk), .rst_n(rst_n),
    .eng(engOut[1]), .stat(engStat[1]));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tally engine pulses mid-cycle, where they have settled
  always @(negedge clk)
  begin
    for (int e = 0; e < 2; e++)
    begin
      if (engOut[e].fetchValid === 1'b1)
      begin
        nF[e]++;
        lastAddr[e] = engOut[e].fetchAddr[31:0];
      end
      if (engOut[e].msiValid === 1'b1)
      begin
        nM[e]++;
        msiTag[e] = {engOut[e].msiClass, engOut[e].msiVector};
      end
    end
    if (engOut[0].wbValid === 1'b1)
    begin
      nW++;
      lastIdx = engOut[0].wbIndex;
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One request, held over its taking edge, then a gap cycle
  task automatic acc(logic w, logic [5:0] m, logic [14:0] a, logic [31:0] d);
    req = '{1'b1, w, m, a, 4'hF, d};
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    seen = rsp;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(logic [5:0] m, logic [14:0] a, logic [31:0] x, string n);
    acc(1'b0, m, a, 32'h0);
    chk(n, seen.valid === 1'b1 ? seen.data : 32'hDEADBEEF, x);
  endtask
  // Bounded wait for an engine to reach a running level
  task automatic idle(int e, int want, logic run);
    int k;
    k = 0;
    while ((engOut[e].running !== run || nF[e] < want) && k < 300)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 300)
    begin
      error_cnt++;
      summarize();
    end
    else
    begin
      // One more edge lets the tally take the last pulses
      @(posedge clk);
      #1;
    end
  endtask
  initial
  begin
    req = '0;
    rst_n = 1'b0;
    cfg = '{3'h2, 3'h1, 4'h4, 16'h1234};
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
      rd(6'h04, 15'(4 * i),
         i == 0 ? 32'h00100000 : 32'h00000000, "ctrl reset");
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b1, 6'h04, 15'(4 * i),
          i % 4 == 3 ? 32'hFFFF0002 : 32'hFFFFFFFF);
      rd(6'h08, 15'(4 * i),
         i % 4 == 0 ? 32'hF1F6FFFF : i % 4 == 3 ? 32'h00000002
         : 32'hFFFFFFFF, "ctrl rw");
    end
    acc(1'b1, 6'h04, 15'h00, 32'h0);
    acc(1'b1, 6'h04, 15'h10, 32'h0);
    idle(0, 0, 1'b0);
    idle(1, 0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, mb[i], 15'h7FFC - 15'(4 * i), 32'hA5A50000 + i);
      rd(mb[(i + 1) % 4], 15'h7FFC - 15'(4 * i),
         32'hA5A50000 + i, "target mem");
    end
    acc(1'b1, 6'h01, 15'h04, 32'h0);
    rd(6'h04, 15'h04, 32'hFFFFFFFF, "csr untouched");
    acc(1'b1, 6'h04, 15'h30, 32'hFFFFFFFF);
    rd(6'h04, 15'h30, 32'h00001234, "err status");
    rd(6'h04, 15'h40, 32'h0, "unmapped");
    rd(6'h00, 15'h00, 32'h0, "no bar");
    nF = '{0, 0};
    nM = '{0, 0};
    nW = 0;
    // Host programs the write engine, two descriptors, no loop
    acc(1'b1, 6'h04, 15'h00, 32'h20360000);
    acc(1'b1, 6'h04, 15'h04, 32'h0);
    acc(1'b1, 6'h04, 15'h08, 32'h00002000);
    acc(1'b1, 6'h04, 15'h0C, 32'h00000001);
    idle(0, 2, 1'b0);
    chk("wr fetches", 32'(nF[0]), 32'd2);
    chk("wr fetch addr", lastAddr[0], 32'h00002010);
    chk("wr msi count", 32'(nM[0]), 32'd2);
    chk("wr msi tag", 32'(msiTag[0]), 32'h43);
    chk("wb count", 32'(nW), 32'd2);
    chk("wb index", 32'(lastIdx), 32'h1);
    rd(6'h04, 15'h0C, 32'h00000001, "wr last idx");
    rd(6'h04, 15'h20, 32'h10410001, "wr status");
    // Read engine loops on one descriptor until bit 31 clears
    acc(1'b1, 6'h08, 15'h10, 32'h80020000);
    acc(1'b1, 6'h08, 15'h18, 32'h00003000);
    acc(1'b1, 6'h08, 15'h1C, 32'h0);
    idle(1, 3, 1'b1);
    chk("still looping", 32'(engOut[1].running), 32'h1);
    acc(1'b1, 6'h08, 15'h10, 32'h00020000);
    idle(1, 3, 1'b0);
    chk("rd refetch base", lastAddr[1], 32'h00003000);
    chk("rd msi seen", 32'(nM[1] >= 3), 32'h1);
    chk("rd msi tag", 32'(msiTag[1]), 32'h0);
    rd(6'h08, 15'h28, 32'h00290000, "rd status");
    summarize();
  end
endmodule
`default_nettype wire
